// >>> wbr_sequencer.sv
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module wbr_sequencer
  import wbr_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [wbr_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [wbr_pkg::DATA_W-1:0] hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [wbr_pkg::DATA_W-1:0]     hrdata,
  output logic                           hresp,
  input  wire logic                      master_clear_n,
  input  wire logic                      brownout_detect,
  input  wire logic                      osc_pin,
  input  wire logic                      erase_active,
  input  wire logic                      sleep_enter,
  input  wire logic                      wake_event,
  input  wire logic                      watchdog_clear_instr,
  input  wire logic                      timer_inc,
  output logic                           core_reset_n,
  output logic                           brownout_arm,
  output logic                           brownout_level,
  output logic                           timer_tick
);
  import wbr_pkg::*;

  wbr_state_t  state_reg;
  wbr_state_t  state_next;
  wbr_cfg_t    cfg_reg;
  wbr_opt_t    opt_reg;
  logic [1:0]  cause_reg;
  logic [1:0]  flags_reg;
  logic [11:0] div_reg;
  logic [10:0] powerup_timer_reg;
  logic [9:0]  ripple_reg;
  logic [7:0]  pre_cnt_reg;
  logic [2:0]  pin_raw;
  logic [2:0]  pin_sync;
  logic        osc_last_reg;
  logic        core_rst_n_reg;
  logic        bor_arm_reg;
  logic        bor_level_reg;
  logic        timer_tick_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;
  logic [31:0] hrdata_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] rd_word;
  logic        lf_tick;
  logic        osc_edge;
  logic        crystal;
  logic        powerup_timer_en;
  logic        powerup_timer_done;
  logic        ost_active;
  logic        ost_done;
  logic        wdt_run;
  logic        wdt_tick;
  logic        wdt_clr;
  logic        wdt_timeout;
  logic        wake_go;
  logic        pre_src;
  logic        pre_wrap;
  logic        timer_hit;
  logic        bor_en;
  logic        bor_hit;
  logic        master_clear_n_hi;
  logic        bus_acc;
  wbr_state_t  after_bor;

  // last prescaler count for a ratio of 2^(sel+extra)
  function automatic logic [7:0] pre_last(input logic [2:0] sel, input logic extra);
    logic [8:0] r;
    r = (9'h001 << ({1'b0, sel} + {3'h0, extra})) - 9'h001;
    return r[7:0];
  endfunction

  // two-stage synchronisers for the pins
  assign pin_raw = {osc_pin, brownout_detect, master_clear_n};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic s1_reg;
    logic s2_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_reg <= PIN_SYNC_RESET[i]; // no false supply-good exit from hold
        s2_reg <= PIN_SYNC_RESET[i];
      end else begin
        s1_reg <= pin_raw[i];
        s2_reg <= s1_reg;
      end
    end
    assign pin_sync[i] = s2_reg;
  end

  assign master_clear_n_hi  = pin_sync[0];
  assign osc_edge = pin_sync[2] & ~osc_last_reg;

  // oscillator edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_last_reg <= 1'b0;
    end else begin
      osc_last_reg <= pin_sync[2];
    end
  end

  // slow oscillator tick enable, one cycle in LF_DIV_CYC
  assign lf_tick = (div_reg == LF_DIV_LAST);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= lf_tick ? 12'h000 : div_reg + 12'h001;
    end
  end

  // configuration decodes
  assign crystal    = (cfg_reg.osc_mode == OSC_CRYSTAL);
  assign powerup_timer_en    = ~cfg_reg.powerup_timer_disable_n;
  assign ost_active = (state_reg == ST_OST) || (state_reg == ST_WOST);
  assign ost_done   = ost_active && osc_edge && (ripple_reg == OST_LAST);
  assign powerup_timer_done  = (state_reg == ST_POWERUP_TIMER) && lf_tick && (powerup_timer_reg == POWERUP_TIMER_LAST);

  // shared prescaler: watchdog when assigned, timer otherwise
  assign pre_src   = opt_reg.prescaler_assign ? lf_tick : timer_inc;
  assign pre_wrap  = pre_src &&
                     (pre_cnt_reg == pre_last(opt_reg.prescale_select,
                                              ~opt_reg.prescaler_assign));
  assign wdt_tick  = opt_reg.prescaler_assign ? pre_wrap : lf_tick;
  assign timer_hit = opt_reg.prescaler_assign ? timer_inc : pre_wrap;

  // watchdog control terms
  assign wdt_run     = cfg_reg.watchdog_enable_fuse &&
                       ((state_reg == ST_RUN) || (state_reg == ST_SLP));
  assign wdt_clr     = watchdog_clear_instr && (state_reg == ST_RUN);
  assign wdt_timeout = wdt_run && wdt_tick && (ripple_reg == WDT_LAST);
  assign wake_go     = (state_reg == ST_SLP) && (wake_event || wdt_timeout);

  // prescaler counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_reg <= 8'h00;
    end else if (wdt_clr && opt_reg.prescaler_assign) begin
      pre_cnt_reg <= 8'h00;
    end else if (wr_pend_reg && (addr_reg == OFS_OPTION)) begin
      pre_cnt_reg <= 8'h00; // reassignment restarts the shared count
    end else if (pre_src) begin
      pre_cnt_reg <= pre_wrap ? 8'h00 : pre_cnt_reg + 8'h01;
    end
  end

  // ripple counter: startup timer while borrowed, watchdog otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ripple_reg <= 10'h000;
    end else if (ost_active) begin
      if (osc_edge) begin
        ripple_reg <= ost_done ? 10'h000 : ripple_reg + 10'h001;
      end
    end else if (!wdt_run || wdt_clr || wake_go || wdt_timeout) begin
      ripple_reg <= 10'h000;
    end else if (wdt_tick) begin
      ripple_reg <= ripple_reg + 10'h001;
    end
  end

  // power-up timer, restarted whenever its state is left
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerup_timer_reg <= 11'h000;
    end else if (state_reg != ST_POWERUP_TIMER) begin
      powerup_timer_reg <= 11'h000;
    end else if (lf_tick) begin
      powerup_timer_reg <= powerup_timer_reg + 11'h001;
    end
  end

  // brown-out enable and level, erase overrides configuration
  always_comb begin
    bor_en = erase_active ||
             (cfg_reg.brownout_enable_sel == BOR_ALWAYS) ||
             ((cfg_reg.brownout_enable_sel == BOR_AWAKE) && (state_reg != ST_SLP));
  end
  assign bor_hit = bor_en && pin_sync[1] && (state_reg != ST_BOR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bor_arm_reg   <= 1'b0;
      bor_level_reg <= BOR_LEVEL_MIN;
    end else begin
      bor_arm_reg   <= bor_en;
      bor_level_reg <= erase_active ? BOR_LEVEL_MIN : cfg_reg.brownout_level_sel;
    end
  end

  // where to go once the supply is good again
  always_comb begin
    if (powerup_timer_en) begin
      after_bor = ST_POWERUP_TIMER;
    end else if (crystal) begin
      after_bor = ST_OST;
    end else begin
      after_bor = ST_MASTER_CLEAR_N;
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOR: begin
        if (!(bor_en && pin_sync[1])) state_next = after_bor;
      end
      ST_POWERUP_TIMER: begin
        if (powerup_timer_done) state_next = crystal ? ST_OST : ST_MASTER_CLEAR_N;
      end
      ST_OST: begin
        if (ost_done) state_next = ST_MASTER_CLEAR_N;
      end
      ST_MASTER_CLEAR_N: begin
        if (master_clear_n_hi) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!master_clear_n_hi || wdt_timeout) state_next = ST_MASTER_CLEAR_N;
        else if (sleep_enter) state_next = ST_SLP;
      end
      ST_SLP: begin
        if (!master_clear_n_hi) state_next = ST_MASTER_CLEAR_N;
        else if (wake_go) state_next = crystal ? ST_WOST : ST_RUN;
      end
      ST_WOST: begin
        if (!master_clear_n_hi) state_next = ST_MASTER_CLEAR_N;
        else if (ost_done) state_next = ST_RUN;
      end
      default: state_next = ST_BOR;
    endcase
    if (bor_hit) state_next = ST_BOR;
  end

  // sequencer state and synchronous core release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= ST_BOR;
      core_rst_n_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      core_rst_n_reg <= (state_next == ST_RUN) || (state_next == ST_SLP);
    end
  end

  // timer tick: shared prescaler wrap, or raw timer_inc while the watchdog has the prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_tick_reg <= 1'b0;
    end else begin
      timer_tick_reg <= timer_hit;
    end
  end

  // timeout flag (bit 1) and powerdown flag (bit 0)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= FLAGS_RESET;
    end else if (bor_hit) begin
      flags_reg <= 2'h3;
    end else if (wdt_timeout && (state_reg == ST_SLP)) begin
      flags_reg <= 2'h0;
    end else if (wdt_timeout) begin
      flags_reg[1] <= 1'b0;
    end else if (sleep_enter && (state_reg == ST_RUN)) begin
      flags_reg <= 2'h2;
    end else if (wdt_clr) begin
      flags_reg <= 2'h3;
    end
  end

  // bus address phase acceptance
  assign bus_acc = hsel && htrans[1] && hready && hreadyout_reg && (hsize == HSIZE_WORD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      addr_reg      <= 8'h00;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      wr_pend_reg   <= bus_acc && hwrite;
      rd_pend_reg   <= bus_acc && !hwrite;
      hreadyout_reg <= !(bus_acc && !hwrite);
      hresp_reg     <= 1'b0;
      if (bus_acc) addr_reg <= haddr[7:0];
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr_reg)
      OFS_CAUSE:  rd_word[1:0] = cause_reg;
      OFS_OPTION: rd_word[3:0] = opt_reg;
      OFS_CONFIG: rd_word[6:0] = cfg_reg;
      OFS_STATUS: rd_word[8:0] = {state_reg, flags_reg};
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  // read data is loaded in the single wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_word;
    end
  end

  // option and configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_reg <= OPTION_RESET;
      cfg_reg <= CONFIG_RESET;
    end else if (wr_pend_reg) begin
      if (addr_reg == OFS_OPTION) opt_reg <= hwdata[3:0];
      if (addr_reg == OFS_CONFIG) cfg_reg <= hwdata[6:0];
    end
  end

  // reset-cause flags: brown-out clear beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_reg <= CAUSE_RESET;
    end else begin
      if (wr_pend_reg && (addr_reg == OFS_CAUSE)) cause_reg <= hwdata[1:0];
      if (bor_hit) cause_reg[0] <= 1'b0;
    end
  end

  assign hreadyout      = hreadyout_reg;
  assign hrdata         = hrdata_reg;
  assign hresp          = hresp_reg;
  assign core_reset_n   = core_rst_n_reg;
  assign brownout_arm   = bor_arm_reg;
  assign brownout_level = bor_level_reg;
  assign timer_tick     = timer_tick_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence powerup_timer_end_s;
    powerup_timer_done && !bor_hit;
  endsequence

  sequence ost_run_s;
    (state_reg == ST_OST) && !bor_hit;
  endsequence

  prescale_share_a: assert property ((opt_reg.prescaler_assign && timer_inc) |=> timer_tick_reg)
    else $error("timer tick lost while prescaler is with watchdog");
  ost_hold_a: assert property (ost_run_s |-> !wdt_timeout && (state_next != ST_RUN))
    else $error("watchdog active during startup count");
  fuse_clear_a: assert property ((!cfg_reg.watchdog_enable_fuse && !ost_active) |=> ripple_reg == 10'h000)
    else $error("watchdog counter not held with fuse clear");
  clear_instr_a: assert property (wdt_clr |=> ripple_reg == 10'h000)
    else $error("watchdog clear instruction ignored");
  bor_field_a: assert property ((!erase_active && !cfg_reg.brownout_enable_sel[1]) |=> !bor_arm_reg)
    else $error("brown-out armed with field 0x");
  erase_force_a: assert property (erase_active |=> bor_arm_reg && (bor_level_reg == BOR_LEVEL_MIN))
    else $error("erase did not force brown-out");
  powerup_timer_restart_a: assert property (((state_reg == ST_POWERUP_TIMER) && bor_hit) |=> (state_reg == ST_BOR) ##1 (powerup_timer_reg == 11'h000))
    else $error("power-up timer not restarted by brown-out");
  powerup_timer_order_a: assert property (powerup_timer_end_s |=> (state_reg == (crystal ? ST_OST : ST_MASTER_CLEAR_N)))
    else $error("startup timer did not follow power-up timer");
  sync_release_a: assert property ((state_reg == ST_MASTER_CLEAR_N && master_clear_n_hi && !bor_hit) |=> core_rst_n_reg && state_reg == ST_RUN)
    else $error("core release not on the next edge");
  bor_cause_a: assert property (bor_hit |=> !cause_reg[0] && flags_reg == 2'h3)
    else $error("brown-out did not clear cause bit 0");
  por_keep_a: assert property (!(wr_pend_reg && addr_reg == OFS_CAUSE) |=> $stable(cause_reg[1]))
    else $error("power-on cause bit changed without a write");
  wdt_reset_a: assert property ((wdt_timeout && state_reg == ST_RUN && !bor_hit) |=> !flags_reg[1] && state_reg == ST_MASTER_CLEAR_N)
    else $error("watchdog reset flags wrong");

endmodule // wbr_sequencer
`default_nettype wire

// >>> wbr_pkg.sv
`default_nettype none
package wbr_pkg;

  // bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;

  // clock rates and derived cycle counts
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned LF_HZ       = 31_000;
  localparam int unsigned LF_DIV_CYC  = CLK_HZ / LF_HZ;
  localparam int unsigned POWERUP_TIMER_MS     = 64;
  localparam int unsigned POWERUP_TIMER_TICKS  = POWERUP_TIMER_MS * LF_HZ / 1000;
  localparam int unsigned WDT_MS      = 17;
  localparam int unsigned WDT_TICKS   = WDT_MS * LF_HZ / 1000;
  localparam int unsigned OST_PERIODS = 1024;

  localparam logic [11:0] LF_DIV_LAST = 12'(LF_DIV_CYC - 1);
  localparam logic [10:0] POWERUP_TIMER_LAST   = 11'(POWERUP_TIMER_TICKS - 1);
  localparam logic [9:0]  WDT_LAST    = 10'(WDT_TICKS - 1);
  localparam logic [9:0]  OST_LAST    = 10'(OST_PERIODS - 1);

  // register byte offsets
  localparam logic [7:0] OFS_CAUSE  = 8'h00;
  localparam logic [7:0] OFS_OPTION = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // values after reset
  localparam logic [1:0] CAUSE_RESET  = 2'h0;
  localparam logic [3:0] OPTION_RESET = 4'hf;
  localparam logic [6:0] CONFIG_RESET = 7'h6d;
  localparam logic [1:0] FLAGS_RESET  = 2'h3;
  // pin synchroniser start values: brown-out reads supply low until synced
  localparam logic [2:0] PIN_SYNC_RESET = 3'b010;

  // field encodings
  localparam logic [1:0] OSC_EXT_RC    = 2'h0;
  localparam logic [1:0] OSC_INTERNAL  = 2'h1;
  localparam logic [1:0] OSC_EXT_CLOCK = 2'h2;
  localparam logic [1:0] OSC_CRYSTAL   = 2'h3;
  localparam logic [1:0] BOR_ALWAYS    = 2'h3;
  localparam logic [1:0] BOR_AWAKE     = 2'h2;
  localparam logic       BOR_LEVEL_MIN = 1'b0;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // configuration word
  typedef struct packed {
    logic [1:0] osc_mode;
    logic       brownout_level_sel;
    logic [1:0] brownout_enable_sel;
    logic       powerup_timer_disable_n;
    logic       watchdog_enable_fuse;
  } wbr_cfg_t;

  // timer option bits
  typedef struct packed {
    logic       prescaler_assign;
    logic [2:0] prescale_select;
  } wbr_opt_t;

  // sequencer states
  typedef enum logic [6:0] {
    ST_BOR  = 7'b0000001,
    ST_POWERUP_TIMER = 7'b0000010,
    ST_OST  = 7'b0000100,
    ST_MASTER_CLEAR_N = 7'b0001000,
    ST_RUN  = 7'b0010000,
    ST_SLP  = 7'b0100000,
    ST_WOST = 7'b1000000
  } wbr_state_t;

endpackage
`default_nettype wire

// >>> wbr_partner.sv
`timescale 1ns/1ns
`default_nettype none
module wbr_partner (
  input  wire logic hclk,
  input  wire logic supply_low,
  input  wire logic master_clear_n_low,
  output logic      master_clear_n,
  output logic      brownout_detect,
  output logic      osc_pin
);
  logic [2:0] osc_cnt;

  initial begin
    master_clear_n  = 1'b1;
    brownout_detect = 1'b1;
    osc_pin         = 1'b0;
    osc_cnt         = 3'h0;
  end

  // pin with weak pull-up, pulled low only while the bench holds it
  always @(posedge hclk) begin
    master_clear_n <= !master_clear_n_low;
  end

  // detector output: high while the supply sits below the trip point
  always @(posedge hclk) begin
    brownout_detect <= supply_low;
  end

  // free-running crystal, one period every 16 system clocks
  always @(posedge hclk) begin
    osc_cnt <= osc_cnt + 3'h1;
    if (osc_cnt == 3'h7) begin
      osc_pin <= !osc_pin;
    end
  end
endmodule // wbr_partner
`default_nettype wire

// >>> watchdog_brownout_reset_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module watchdog_brownout_reset_sequencer_tb;
  import wbr_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        master_clear_n;
  logic        brownout_detect;
  logic        osc_pin;
  logic        erase_active;
  logic        sleep_enter;
  logic        wake_event;
  logic        watchdog_clear_instr;
  logic        timer_inc;
  logic        core_reset_n;
  logic        brownout_arm;
  logic        brownout_level;
  logic        timer_tick;
  logic        supply_low;
  logic        master_clear_n_low;
  int          errors;
  int          check_count;
  int          ticks;
  int          n;
  int          cause_m;
  int          opt_m;
  int          cfg_m;
  logic [31:0] rd;

  wbr_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .master_clear_n(master_clear_n),
    .brownout_detect(brownout_detect), .osc_pin(osc_pin), .erase_active(erase_active),
    .sleep_enter(sleep_enter), .wake_event(wake_event),
    .watchdog_clear_instr(watchdog_clear_instr), .timer_inc(timer_inc),
    .core_reset_n(core_reset_n), .brownout_arm(brownout_arm),
    .brownout_level(brownout_level), .timer_tick(timer_tick));

  wbr_partner far_side (.hclk(hclk), .supply_low(supply_low), .master_clear_n_low(master_clear_n_low),
    .master_clear_n(master_clear_n), .brownout_detect(brownout_detect), .osc_pin(osc_pin));

  // 125 MHz system clock
  always #4 hclk = !hclk;

  // counts prescaled timer increments
  always @(posedge hclk) begin
    if (timer_tick === 1'b1) ticks <= ticks + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // write and mirror into the reference model
  task automatic wr(input logic [7:0] a, input int d);
    bus(1'b1, a, 32'(d));
    if (a == OFS_CAUSE) cause_m = d & 3;
    if (a == OFS_OPTION) opt_m = d & 15;
    if (a == OFS_CONFIG) cfg_m = d & 127;
  endtask

  task automatic rdchk(input logic [7:0] a, input int e);
    bus(1'b0, a, 32'h0);
    check(rd, 32'(e));
    check(32'(hresp), 32'h0);
  endtask

  function automatic int mdl(input logic [7:0] a);
    return (a == OFS_CAUSE) ? cause_m : (a == OFS_OPTION) ? opt_m : (a == OFS_CONFIG) ? cfg_m : 0;
  endfunction

  // status word: one-hot state above the timeout and powerdown flags
  function automatic int st(input int s, input int to, input int pd);
    return (1 << (s + 2)) | (to << 1) | pd;
  endfunction

  task automatic wait_core(input int lim);
    n = 0;
    while (core_reset_n !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // one-cycle core event: 0 sleep, 1 wake, 2 watchdog clear
  task automatic pulse(input int which);
    sleep_enter          <= (which == 0);
    wake_event           <= (which == 1);
    watchdog_clear_instr <= (which == 2);
    @(posedge hclk);
    sleep_enter          <= 1'b0;
    wake_event           <= 1'b0;
    watchdog_clear_instr <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic finish_test;
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(8 * 70000);
    errors++;
    finish_test();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0;
    hwdata = 0; erase_active = 0; sleep_enter = 0; wake_event = 0;
    watchdog_clear_instr = 0; timer_inc = 0; supply_low = 1; master_clear_n_low = 0;
    errors = 0; check_count = 0; ticks = 0;
    cause_m = 0; opt_m = 15; cfg_m = 109;
    void'($urandom(32'h07d8f24f));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped offset, read-back
    for (int a = 0; a < 12; a += 4) rdchk(8'(a), mdl(8'(a)));
    rdchk(OFS_STATUS, st(0, 1, 1));
    rdchk(8'h10, 0);
    $display("test reset values done");
    // brown-out enable, level and erase override
    for (int i = 0; i < 16; i++) begin
      wr(OFS_CONFIG, 32'h63 | ((i & 3) << 2) | (((i >> 2) & 1) << 4));
      erase_active <= i[3];
      repeat (3) @(posedge hclk);
      check(brownout_arm, i[3] | ((i & 3) >= 2));
      check(brownout_level, i[3] ? BOR_LEVEL_MIN : i[2]);
      rdchk(OFS_CONFIG, mdl(OFS_CONFIG));
    end
    erase_active <= 1'b0;
    wr(OFS_CONFIG, 109);
    $display("test brown-out control done");
    // brown-out while the power-up timer runs sends it back to hold
    supply_low <= 1'b0;
    repeat (8) @(posedge hclk);
    rdchk(OFS_STATUS, st(1, 1, 1));
    supply_low <= 1'b1;
    repeat (8) @(posedge hclk);
    rdchk(OFS_STATUS, st(0, 1, 1));
    check(core_reset_n, 1'b0);
    $display("test power-up restart done");
    // no time-out in internal mode; master clear alone holds, release runs at once
    wr(OFS_CONFIG, 32'h2f);
    master_clear_n_low <= 1'b1;
    supply_low <= 1'b0;
    repeat (10) @(posedge hclk);
    rdchk(OFS_STATUS, st(3, 1, 1));
    check(core_reset_n, 1'b0);
    master_clear_n_low <= 1'b0;
    wait_core(40);
    check(n <= 10, 1'b1);
    rdchk(OFS_STATUS, st(4, 1, 1));
    $display("test master clear done");
    // cause flags: software sets, brown-out clears bit 0 only
    wr(OFS_CAUSE, 3);
    rdchk(OFS_CAUSE, mdl(OFS_CAUSE));
    supply_low <= 1'b1;
    repeat (8) @(posedge hclk);
    supply_low <= 1'b0;
    cause_m = cause_m & 2;
    wait_core(40);
    rdchk(OFS_CAUSE, mdl(OFS_CAUSE));
    $display("test cause flags done");
    // crystal mode without power-up timer: 1024 oscillator periods alone
    wr(OFS_CONFIG, 32'h6f);
    supply_low <= 1'b1;
    repeat (8) @(posedge hclk);
    supply_low <= 1'b0;
    wait_core(OST_PERIODS * 16 + 200);
    check(n >= (OST_PERIODS - 1) * 16 && n <= OST_PERIODS * 16 + 40, 1'b1);
    rdchk(OFS_STATUS, st(4, 1, 1));
    $display("test crystal start-up done");
    // sleep with enable 10, crystal wake through the start-up count
    wr(OFS_CONFIG, 32'h6b);
    pulse(0);
    rdchk(OFS_STATUS, st(5, 1, 0));
    check(brownout_arm, 1'b0);
    pulse(1);
    rdchk(OFS_STATUS, st(6, 1, 0));
    repeat (OST_PERIODS * 16 + 100) @(posedge hclk);
    rdchk(OFS_STATUS, st(4, 1, 0));
    check(brownout_arm, 1'b1);
    pulse(2);
    rdchk(OFS_STATUS, st(4, 1, 1));
    $display("test sleep and wake done");
    // external RC and external clock: wake is immediate, no start-up count
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CONFIG, 32'h0b | (m << 6));
      pulse(0);
      rdchk(OFS_STATUS, st(5, 1, 0));
      pulse(1);
      rdchk(OFS_STATUS, st(4, 1, 0));
      pulse(2);
      rdchk(OFS_STATUS, st(4, 1, 1));
    end
    $display("test non-crystal wake done");
    // shared prescaler: timer divided by 2^(sel+1), or raw when given to the watchdog
    for (int s = 0; s < 9; s++) begin
      wr(OFS_OPTION, (s == 8) ? (8 | $urandom_range(0, 7)) : s);
      rdchk(OFS_OPTION, mdl(OFS_OPTION));
      ticks = 0;
      for (int p = 0; p < ((s == 8) ? 20 : 3 << (s + 1)); p++) begin
        timer_inc <= 1'b1;
        @(posedge hclk);
        timer_inc <= 1'b0;
        repeat (1 + $urandom_range(0, 2)) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
      check(ticks, (s == 8) ? 20 : 3);
    end
    $display("test prescaler done");
    finish_test();
  end
endmodule // watchdog_brownout_reset_sequencer_tb
`default_nettype wire
